// ==== design/ccrc_pkg.sv ====
// ccrc_pkg: register map, field positions, mode codes and seeds
// assumes byte-wide core register accesses on a single system clock
package ccrc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CONFIG = 16'ha078;
    localparam logic [15:0] ADDR_DATA0  = 16'ha07c;
    localparam logic [15:0] ADDR_DATA1  = 16'ha07d;
    localparam logic [15:0] ADDR_DATA2  = 16'ha07e;
    localparam logic [15:0] ADDR_DATA3  = 16'ha07f;
    localparam int          ADDR_W      = 16;
    localparam int          DATA_W      = 8;
    // ------------------------------------------------------------
    // config field positions and reset
    // ------------------------------------------------------------
    localparam int         WIDTH_LSB    = 6;
    localparam int         REV_BIT      = 5;
    localparam int         CARRY_DISCARD_BIT  = 4;
    localparam int         SEED_BIT     = 3;
    localparam int         BUSY_BIT     = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;
    // ------------------------------------------------------------
    // input width codes
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_24 = 2'h2;
    localparam logic [1:0] WIDTH_32 = 2'h3;
    // ------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_CSUM8  = 3'h1;
    localparam logic [2:0] MODE_CSUM32 = 3'h2;
    localparam logic [2:0] MODE_CRC16A = 3'h3;
    localparam logic [2:0] MODE_CRC16B = 3'h4;
    localparam logic [2:0] MODE_CRC32  = 3'h5;
    localparam logic [2:0] MODE_RSVD   = 3'h6;
    localparam logic [2:0] MODE_CLEAR  = 3'h7;
    // ------------------------------------------------------------
    // polynomials, seeds, masks
    // ------------------------------------------------------------
    localparam logic [31:0] POLY_CRC16A = 32'h0000_8005;
    localparam logic [31:0] POLY_CRC16B = 32'h0000_1021;
    localparam logic [31:0] POLY_CRC32  = 32'h04c1_1db7;
    localparam logic [31:0] SEED_CSUM   = 32'h0000_0000;
    localparam logic [31:0] SEED_CRC16  = 32'h0000_ffff;
    localparam logic [31:0] SEED_CRC32  = 32'hffff_ffff;
    localparam logic [31:0] MASK_8      = 32'h0000_00ff;
    localparam logic [31:0] MASK_16     = 32'h0000_ffff;
    localparam logic [31:0] MASK_32     = 32'hffff_ffff;
endpackage : ccrc_pkg

// ==== design/ccrc_bus_if.sv ====
// ccrc_bus_if: byte register bus between core side and accelerator
// assumes both ends on the same clk; rdata follows addr in-cycle
interface ccrc_bus_if;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr_stb;
    logic [7:0]  rdata;

    modport device (
        input  addr,
        input  wdata,
        input  wr_stb,
        output rdata
    );
    modport host (
        output addr,
        output wdata,
        output wr_stb,
        input  rdata
    );
endinterface : ccrc_bus_if

// ==== design/ccrc_host.sv ====
// ccrc_host: core side, turns user requests into register accesses
// assumes software keeps the mode/clear/data ordering itself
module ccrc_host (
    input  wire logic        clk,
    input  wire logic        srst,
    ccrc_bus_if.host         bus,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [7:0]       resp_data
);
    // ------------------------------------------------------------
    // request stage
    // ------------------------------------------------------------
    logic [15:0] addr_reg;
    logic [7:0]  wdata_reg;
    logic        wr_reg;
    logic        rd_reg;
    logic        resp_valid_reg;
    logic [7:0]  resp_data_reg;

    // no busy polling: every request is accepted at once, even while a result is still pending
    assign req_ready  = 1'b1;
    assign bus.addr   = addr_reg;
    assign bus.wdata  = wdata_reg;
    assign bus.wr_stb = wr_reg;
    assign resp_valid = resp_valid_reg;
    assign resp_data  = resp_data_reg;

    // requests forwarded strictly in order, so software byte order holds
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_reg       <= ccrc_pkg::ADDR_CONFIG;
            wdata_reg      <= ccrc_pkg::DATA_RESET;
            wr_reg         <= 1'b0;
            rd_reg         <= 1'b0;
            resp_valid_reg <= 1'b0;
            resp_data_reg  <= ccrc_pkg::DATA_RESET;
        end else begin
            wr_reg         <= req_valid && req_write;
            rd_reg         <= req_valid && !req_write;
            resp_valid_reg <= rd_reg;
            if (req_valid) begin
                addr_reg  <= req_addr;
                wdata_reg <= req_wdata;
            end
            if (rd_reg) begin
                resp_data_reg <= bus.rdata;
            end
        end
    end
endmodule : ccrc_host

// ==== design/ccrc_device.sv ====
// ccrc_device: checksum/crc accelerator with byte register port
// assumes the core writes high data bytes before byte 0
// Operation
// - width code 0..3 means 8/16/24/32 bits
// - one byte processed per clock cycle; the 32-bit checksum adds its whole word in the last busy cycle
// - reverse flag feeds input msb first
// - seeds and results never bit reversed
// - checksum adds previous carry unless discarded
// - seed flag routes data writes into seed
// - mode 000 disables the accelerator
// - modes 001/010 select 8/32-bit checksum
// - mode 011 selects crc-16 poly 8005
// - mode 100 selects crc-16 poly 1021
// - mode 101 crc-32, mode 110 reserved
// - code 111 clears state, restores default seed
// - software sets mode, then clear, then data
// - busy reads one while calculation pending
// - software need not poll busy at 8-bit width; wider words must wait for busy clear
// - 8-bit width uses only byte 0
// - software writes high bytes before byte 0
// - byte 0 write starts calc or loads seed
// - result readable from data registers unreversed
// - data bytes 1-3 held, reset zero
module ccrc_device (
    input  wire logic        clk,
    input  wire logic        srst,
    ccrc_bus_if.device       bus,
    output logic             busy,
    output logic [31:0]      result
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]  width_reg;
    logic        rev_reg;
    logic        carry_discard_reg;
    logic        seed_reg;
    logic [2:0]  mode_reg;
    logic [23:0] entry_reg;
    logic [31:0] full_reg;
    logic [31:0] shift_reg;
    logic [2:0]  cnt_reg;
    logic [31:0] state_reg;
    logic        carry_reg;
    logic [31:0] state_next;
    logic        carry_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire cfg_sel = bus.addr == ccrc_pkg::ADDR_CONFIG;
    wire d0_sel  = bus.addr == ccrc_pkg::ADDR_DATA0;
    wire d1_sel  = bus.addr == ccrc_pkg::ADDR_DATA1;
    wire d2_sel  = bus.addr == ccrc_pkg::ADDR_DATA2;
    wire d3_sel  = bus.addr == ccrc_pkg::ADDR_DATA3;
    wire cfg_wr  = bus.wr_stb && cfg_sel;
    wire d0_wr   = bus.wr_stb && d0_sel;
    wire [2:0] wr_mode = bus.wdata[2:0];
    wire clear_cmd = cfg_wr && wr_mode == ccrc_pkg::MODE_CLEAR;
    wire mode_ok = mode_reg != ccrc_pkg::MODE_OFF &&
                   mode_reg != ccrc_pkg::MODE_RSVD;
    wire start   = d0_wr && !seed_reg && mode_ok;
    wire last    = cnt_reg == 3'h1;

    // ------------------------------------------------------------
    // input word: width mask and optional reversal
    // ------------------------------------------------------------
    wire [31:0] raw_word  = {entry_reg, bus.wdata};
    wire [4:0]  pad_bits  = {~width_reg, 3'h0};
    wire [31:0] width_msk = ccrc_pkg::MASK_32 >> pad_bits;
    wire [31:0] rev_full  = {<<{raw_word}};
    wire [31:0] rev_word  = rev_full >> pad_bits;
    wire [31:0] in_word   = rev_reg ? rev_word : (raw_word & width_msk);
    wire [2:0]  in_bytes  = {1'b0, width_reg} + 3'h1;
    wire is_crc16 = mode_reg == ccrc_pkg::MODE_CRC16A ||
                    mode_reg == ccrc_pkg::MODE_CRC16B;
    wire [31:0] seed_msk  = mode_reg == ccrc_pkg::MODE_CSUM8 ?
                            ccrc_pkg::MASK_8 :
                            (is_crc16 ? ccrc_pkg::MASK_16 : ccrc_pkg::MASK_32);
    // seed taken in plain bit order whatever the reverse flag says
    wire [31:0] seed_word = raw_word & seed_msk;
    wire [31:0] def_seed  = mode_reg == ccrc_pkg::MODE_CRC32 ?
                            ccrc_pkg::SEED_CRC32 :
                            (is_crc16 ? ccrc_pkg::SEED_CRC16 :
                             ccrc_pkg::SEED_CSUM);

    // ------------------------------------------------------------
    // crc byte step, lsb of the fed byte first
    // ------------------------------------------------------------
    function automatic logic [31:0] crc_byte(
        input logic [31:0] crc,
        input logic [7:0]  dat,
        input logic        wide,
        input logic [31:0] poly
    );
        logic [31:0] c;
        logic        fb;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            fb = (wide ? c[31] : c[15]) ^ dat[i];
            c  = {c[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
        end
        crc_byte = wide ? c : (c & ccrc_pkg::MASK_16);
    endfunction : crc_byte

    // ------------------------------------------------------------
    // per-cycle calculation
    // ------------------------------------------------------------
    wire [7:0]  cur_byte = shift_reg[7:0];
    wire        cin      = carry_reg && !carry_discard_reg;
    wire [8:0]  sum9     = {1'b0, state_reg[7:0]} + {1'b0, cur_byte} +
                           {8'h00, cin};
    wire [32:0] sum33    = {1'b0, state_reg} + {1'b0, full_reg} +
                           {32'h0000_0000, cin};

    always_comb begin
        state_next = state_reg;
        carry_next = carry_reg;
        unique case (mode_reg)
            ccrc_pkg::MODE_CSUM8: begin
                state_next = {24'h00_0000, sum9[7:0]};
                carry_next = sum9[8];
            end
            ccrc_pkg::MODE_CSUM32: begin
                // whole word added once, remaining cycles only hold busy
                if (last) begin
                    state_next = sum33[31:0];
                    carry_next = sum33[32];
                end
            end
            ccrc_pkg::MODE_CRC16A: begin
                state_next = crc_byte(state_reg, cur_byte, 1'b0,
                                      ccrc_pkg::POLY_CRC16A);
            end
            ccrc_pkg::MODE_CRC16B: begin
                state_next = crc_byte(state_reg, cur_byte, 1'b0,
                                      ccrc_pkg::POLY_CRC16B);
            end
            ccrc_pkg::MODE_CRC32: begin
                state_next = crc_byte(state_reg, cur_byte, 1'b1,
                                      ccrc_pkg::POLY_CRC32);
            end
            default: begin
                state_next = state_reg;
                carry_next = carry_reg;
            end
        endcase
    end

    // ------------------------------------------------------------
    // config and data entry
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            width_reg   <= ccrc_pkg::CONFIG_RESET[7:6];
            rev_reg     <= ccrc_pkg::CONFIG_RESET[5];
            carry_discard_reg <= ccrc_pkg::CONFIG_RESET[4];
            seed_reg    <= ccrc_pkg::CONFIG_RESET[3];
            mode_reg    <= ccrc_pkg::CONFIG_RESET[2:0];
            entry_reg   <= {3{ccrc_pkg::DATA_RESET}};
        end else begin
            if (cfg_wr) begin
                width_reg   <= bus.wdata[ccrc_pkg::WIDTH_LSB +: 2];
                rev_reg     <= bus.wdata[ccrc_pkg::REV_BIT];
                carry_discard_reg <= bus.wdata[ccrc_pkg::CARRY_DISCARD_BIT];
                seed_reg    <= bus.wdata[ccrc_pkg::SEED_BIT];
                // clear code is a command: the selected mode stays
                if (!clear_cmd) begin
                    mode_reg <= wr_mode;
                end
            end
            if (bus.wr_stb && d1_sel) begin
                entry_reg[7:0] <= bus.wdata;
            end
            if (bus.wr_stb && d2_sel) begin
                entry_reg[15:8] <= bus.wdata;
            end
            if (bus.wr_stb && d3_sel) begin
                entry_reg[23:16] <= bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // calculation state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            full_reg  <= ccrc_pkg::SEED_CSUM;
            shift_reg <= ccrc_pkg::SEED_CSUM;
            cnt_reg   <= 3'h0;
            state_reg <= ccrc_pkg::SEED_CSUM;
            carry_reg <= 1'b0;
        end else if (clear_cmd) begin
            cnt_reg   <= 3'h0;
            state_reg <= def_seed;
            carry_reg <= 1'b0;
        end else if (cfg_wr && !(wr_mode != ccrc_pkg::MODE_OFF &&
                                 wr_mode != ccrc_pkg::MODE_RSVD)) begin
            cnt_reg <= 3'h0;
        end else if (d0_wr && seed_reg) begin
            cnt_reg   <= 3'h0;
            state_reg <= seed_word;
            carry_reg <= 1'b0;
        end else if (start) begin
            full_reg  <= in_word;
            shift_reg <= in_word;
            cnt_reg   <= in_bytes;
            // only the byte in flight is committed, so back-to-back 8-bit
            // writes never drop a word; wider words lose their remaining bytes
            if (cnt_reg != 3'h0 && mode_ok) begin
                state_reg <= state_next;
                carry_reg <= carry_next;
            end
        end else if (cnt_reg != 3'h0 && mode_ok) begin
            shift_reg <= shift_reg >> 8;
            cnt_reg   <= cnt_reg - 3'h1;
            state_reg <= state_next;
            carry_reg <= carry_next;
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    assign busy   = cnt_reg != 3'h0;
    assign result = state_reg;
    wire [7:0] cfg_rd = {width_reg, rev_reg, carry_discard_reg, seed_reg,
                         2'b00, busy};
    assign bus.rdata = cfg_sel ? cfg_rd :
                       d0_sel  ? state_reg[7:0] :
                       d1_sel  ? state_reg[15:8] :
                       d2_sel  ? state_reg[23:16] :
                       d3_sel  ? state_reg[31:24] :
                       8'h00;
endmodule : ccrc_device

// ==== sim/ccrc_asserts.sv ====
// ccrc_asserts: checks on the register bus and accelerator outputs
// assumes one clock, srst synchronous, placed beside the interface
module ccrc_asserts (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr_stb,
    input wire logic [7:0]  rdata,
    input wire logic        busy,
    input wire logic [31:0] result
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // shadow of config, mode and entry bytes
    // ----------------------------------------
    logic [7:0]  cfg_reg, b1_reg, b2_reg, b3_reg;
    logic [2:0]  mode_reg, cnt_reg, cnt_next;
    wire         cfg_wr = wr_stb && addr == 16'ha078;
    wire         d0_wr  = wr_stb && addr == 16'ha07c;
    wire [2:0]   wmode  = wdata[2:0];
    wire         calc   = mode_reg != 3'h0 && mode_reg != 3'h6;
    wire         stop   = cfg_wr && (wmode == 3'h0 || wmode >= 3'h6);
    wire         crc16  = mode_reg == 3'h3 || mode_reg == 3'h4;
    wire [31:0]  dflt   = mode_reg == 3'h5 ? 32'hffff_ffff
                        : crc16 ? 32'h0000_ffff : 32'h0000_0000;
    wire [31:0]  smask  = mode_reg == 3'h1 ? 32'h0000_00ff
                        : crc16 ? 32'h0000_ffff : 32'hffff_ffff;
    wire [31:0]  sval   = {b3_reg, b2_reg, b1_reg, wdata} & smask;
    wire         mapped = addr == 16'ha078 || addr[15:2] == 14'h281f;
    // a seed write cancels, a data write restarts the count
    assign cnt_next = stop ? 3'h0
                    : d0_wr && calc ? (cfg_reg[3] ? 3'h0
                                       : {1'b0, cfg_reg[7:6]} + 3'h1)
                    : cnt_reg != 3'h0 ? cnt_reg - 3'h1 : 3'h0;
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_reg  <= 8'h00;
            mode_reg <= 3'h0;
            cnt_reg  <= 3'h0;
            b1_reg   <= 8'h00;
            b2_reg   <= 8'h00;
            b3_reg   <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
            if (cfg_wr) cfg_reg <= wdata;
            if (cfg_wr && wmode != 3'h7) mode_reg <= wmode;
            if (wr_stb && addr == 16'ha07d) b1_reg <= wdata;
            if (wr_stb && addr == 16'ha07e) b2_reg <= wdata;
            if (wr_stb && addr == 16'ha07f) b3_reg <= wdata;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_busy_span: assert property (busy == (cnt_reg != 3'h0))
        else $error("busy length differs from input width");
    a_cfg_readback: assert property (addr == 16'ha078 |->
        rdata == {cfg_reg[7:3], 2'b00, cnt_reg != 3'h0})
        else $error("config read");
    a_busy_bit: assert property (addr == 16'ha078 && cnt_reg != 3'h0 |->
        rdata[0]) else $error("busy bit not shown");
    a_low_result: assert property (addr == 16'ha07c |->
        rdata == result[7:0]) else $error("byte 0 read");
    a_top_result: assert property (addr == 16'ha07f |->
        rdata == result[31:24]) else $error("byte 3 read");
    a_unmapped_zero: assert property (!mapped |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_clear_seed: assert property (cfg_wr && wmode == 3'h7 && calc
        |=> result == $past(dflt)) else $error("default seed");
    a_seed_load: assert property (d0_wr && cfg_reg[3] && calc
        |=> result == $past(sval)) else $error("seed load");
    a_idle_hold: assert property (!busy && !wr_stb |=> $stable(result))
        else $error("result moved while idle");
    a_off_still: assert property (d0_wr && !calc && !cfg_reg[3]
        |=> !busy && $stable(result)) else $error("calc while off");
endmodule : ccrc_asserts

// ==== sim/ccrc_test.sv ====
// ccrc_test: drives the core side and models the accelerator
// assumes the host forwards requests in order, one clock domain
module ccrc_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic [7:0]  resp_data, f;
    logic [7:0]  m_cfg = 8'h00;
    logic        resp_valid, busy, req_ready;
    logic        m_cy = 1'b0;
    logic [2:0]  m_mode = 3'h0;
    logic [31:0] result;
    logic [31:0] m_st = 32'h0000_0000;
    int          fail_count = 0;
    int          checks_done = 0;
    int          seed = 32'h1eb6f9ea;
    ccrc_bus_if  bus ();
    always #5 clk = ~clk;
    ccrc_host u_ccrc_host (.clk(clk), .srst(srst), .bus(bus),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_data(resp_data));
    ccrc_device u_ccrc_device (.clk(clk), .srst(srst), .bus(bus),
        .busy(busy), .result(result));
    ccrc_asserts u_ccrc_asserts (.clk(clk), .srst(srst), .addr(bus.addr),
        .wdata(bus.wdata), .wr_stb(bus.wr_stb), .rdata(bus.rdata),
        .busy(busy), .result(result));
    // ----------------------------------------
    // tasks and model
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // valid stays up so requests can run back to back
    task automatic req(input logic w, input logic [15:0] a, logic [7:0] d);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #1;
    endtask : req
    task automatic wait_for(input bit rsp);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            if (rsp ? resp_valid === 1'b1 : i > 0 && busy === 1'b0) return;
        end
        fail_count++;
        tally_and_finish();
    endtask : wait_for
    task automatic rd(input string nm, input logic [15:0] a, logic [7:0] e);
        req(1'b0, a, 8'h00);
        req_valid = 1'b0;
        wait_for(1'b1);
        chk(nm, {24'h0, e}, {24'h0, resp_data});
    endtask : rd
    function automatic void step(input logic [31:0] w);
        int          n;
        logic [32:0] s;
        logic        fb;
        n = 8 * (int'(m_cfg[7:6]) + 1);
        if (n < 32) w = w & ((32'h1 << n) - 32'h1);
        if (m_cfg[5]) begin
            w = {<<{w}};
            w = w >> (32 - n);
        end
        // 8-bit checksum: bytes added one by one, carry chained; 32-bit adds the word at once
        if (m_mode == 3'h1) begin
            for (int i = 0; i < n; i += 8) begin
                s = m_st[7:0] + w[i +: 8] + (m_cfg[4] ? 1'b0 : m_cy);
                {m_cy, m_st} = {s[8], 24'h00_0000, s[7:0]};
            end
        end else if (m_mode == 3'h2) begin
            {m_cy, m_st} = m_st + w + (m_cfg[4] ? 1'b0 : m_cy);
        end
        if (m_mode >= 3'h3) for (int i = 0; i < n; i++) begin
            fb = w[i] ^ (m_mode == 3'h5 ? m_st[31] : m_st[15]);
            m_st = m_st << 1;
            if (m_mode != 3'h5) m_st[31:16] = 16'h0000;
            if (fb) m_st ^= m_mode == 3'h3 ? 32'h0000_8005
                : m_mode == 3'h4 ? 32'h0000_1021 : 32'h04c1_1db7;
        end
    endfunction : step
    task automatic cfg(input logic [7:0] v);
        req(1'b1, 16'ha078, v);
        m_cfg = v;
        if (v[2:0] != 3'h7) m_mode = v[2:0];
        else m_st = m_mode == 3'h5 ? 32'hffff_ffff
            : m_mode inside {3'h3, 3'h4} ? 32'h0000_ffff : 32'h0000_0000;
        if (v[2:0] == 3'h7) m_cy = 1'b0;
        rd("config", 16'ha078, {v[7:3], 3'b000});
        chk("state after config", m_st, result);
    endtask : cfg
    task automatic word(input logic [31:0] w);
        int j;
        // high bytes first, byte 0 last starts the calculation
        for (int b = m_cfg[7:6]; b >= 0; b--) begin
            req(1'b1, 16'ha07c + 16'(b), w[8*b +: 8]);
        end
        req_valid = 1'b0;
        if (m_mode != 3'h0 && m_mode != 3'h6) step(w);
        wait_for(1'b0);
        chk("result", m_st, result);
        j = $random(seed) & 3;
        rd("data byte", 16'ha07c + 16'(j), m_st[8*j +: 8]);
    endtask : word
    task automatic load(input logic [31:0] v);
        cfg({m_cfg[7:4], 1'b1, m_mode});
        for (int b = 3; b >= 0; b--) begin
            req(1'b1, 16'ha07c + 16'(b), v[8*b +: 8]);
        end
        m_st = v & (m_mode == 3'h1 ? 32'h0000_00ff
            : m_mode inside {3'h3, 3'h4} ? 32'h0000_ffff : 32'hffff_ffff);
        m_cy = 1'b0;
        cfg({m_cfg[7:4], 1'b0, m_mode});
    endtask : load
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk);
        #1;
        rd("config reset", 16'ha078, 8'h00);
        rd("byte 2 reset", 16'ha07e, 8'h00);
        rd("unmapped", 16'ha079, 8'h00);
        for (int m = 1; m <= 5; m++) begin
            f = 8'($random(seed)) & 8'hf0;
            cfg(f | 8'(m));
            cfg(f | 8'h07);
            for (int k = 0; k < 4; k++) word($random(seed));
            load($random(seed));
            word($random(seed));
        end
        cfg({m_cfg[7:3], 3'h6});
        word($random(seed));
        cfg({m_cfg[7:3], 3'h0});
        word($random(seed));
        cfg(8'h01);
        cfg(8'h07);
        // bytes each cycle, no busy polling in between
        for (int k = 0; k < 3; k++) begin
            f = 8'($random(seed));
            req(1'b1, 16'ha07c, f);
            step({24'h0, f});
            chk("ready", 32'h1, {31'h0, req_ready});
        end
        // read issued right behind the last byte still sees busy set
        rd("busy flag", 16'ha078, 8'h01);
        wait_for(1'b0);
        chk("back to back", m_st, result);
        tally_and_finish();
    end
endmodule : ccrc_test
